// ==== desd_codec.sv ====
`timescale 1ns/10ps

// What this block does
// RL1: Encode does nothing while condition is off
// RL2: Encode writes highest set bit index digit
// RL3: Caller keeps two low designator digits 0..3
// RL4: Encode up to four consecutive source words
// RL5: Low digit first position, next digit count
// RL6: Result digits wrap to digit zero
// RL7: Caller keeps source words in one area
// RL8: Encode errors on bad designator or range
// RL9: Encode errors on any zero source word
// RL10: Invalid indirect operand sets the error flag
// RL11: Segment decode does nothing while condition off
// RL12: Each source digit becomes 8-bit segment code
// RL13: Codes fill consecutive byte halves from start
// RL14: Digits give first, count, starting byte half
// RL15: Source digits wrap to digit zero
// RL16: Segment a bit 0, g bit 6, bit 7 clear
// RL17: Fixed code table for hex 0 to F
// RL18: Segment errors on bad designator or range
module desd_codec #(
  parameter int unsigned ADDR_W = desd_pkg::DESD_ADDR_W
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       reset,
  // Instruction request from the sequencer
  input  wire logic                       req_valid,
  input  wire desd_pkg::desd_req_type     req,
  // Operation status back to the sequencer
  output logic                            busy,
  output logic                            done,
  output logic                            error_flag,
  // Operand memory port
  output desd_pkg::desd_mem_req_type      mem_req,
  input  wire desd_pkg::desd_mem_rsp_type mem_rsp
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  // Addresses travel in 16-bit struct fields, so wider ones cannot be served
  if (ADDR_W != desd_pkg::DESD_WORD_W) begin : g_bad_width
    $error("desd_codec: ADDR_W must equal the 16-bit carrier width");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    desd_pkg::desd_state_type st;       // Sequence state
    desd_pkg::desd_op_type    op;       // Latched operation
    logic [15:0]              di;       // Latched designator
    logic [15:0]              src;      // Source address
    logic [15:0]              dst;      // Result or destination address
    logic [15:0]              last;     // Area limit
    logic                     ind_bad;  // Latched indirect error
    logic                     phase;    // 0: first read, 1: loop reads
    logic [2:0]               idx;      // Current item
    logic [15:0]              buf_w;    // Result word under construction
    logic [15:0]              src_w;    // Source word for segment decode
    desd_pkg::desd_mem_req_type mem;    // Memory strobes
    logic                     done;     // Completion pulse
    logic                     err;      // Error flag
    logic                     busy;     // Operation in progress
  } desd_regs_type;

  desd_regs_type s_r;   // Registered state
  desd_regs_type s_nxt; // Next state

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // One designator digit
  function automatic logic [3:0] desd_nib(input logic [15:0] w, input int unsigned n);
    desd_nib = w[n*4 +: 4];
  endfunction

  // Item count, designator digit one plus one
  function automatic logic [2:0] desd_count(input logic [15:0] di);
    desd_count = 3'(desd_nib(di, desd_pkg::DESD_NIB_COUNT)) + 3'd1;
  endfunction

  // Index of the highest set bit; caller rules out zero
  function automatic logic [3:0] desd_msb(input logic [15:0] w);
    desd_msb = 4'h0;
    for (int unsigned b = 0; b < desd_pkg::DESD_WORD_W; b++) begin
      if (w[b]) begin
        desd_msb = 4'(b);
      end
    end
  endfunction

  // Segment code, a in bit 0 through g in bit 6, bit 7 kept clear
  function automatic logic [7:0] desd_seg(input logic [3:0] d);
    unique case (d)
      4'h0: desd_seg = 8'h3F;
      4'h1: desd_seg = 8'h06;
      4'h2: desd_seg = 8'h5B;
      4'h3: desd_seg = 8'h4F;
      4'h4: desd_seg = 8'h66;
      4'h5: desd_seg = 8'h6D;
      4'h6: desd_seg = 8'h7D;
      4'h7: desd_seg = 8'h27;
      4'h8: desd_seg = 8'h7F;
      4'h9: desd_seg = 8'h6F;
      4'hA: desd_seg = 8'h77;
      4'hB: desd_seg = 8'h7C;
      4'hC: desd_seg = 8'h39;
      4'hD: desd_seg = 8'h5E;
      4'hE: desd_seg = 8'h79;
      4'hF: desd_seg = 8'h71;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  // Derived values of the latched request
  logic [2:0]  cnt;       // Number of items
  logic [1:0]  first_dg;  // First digit position
  logic [2:0]  pos;       // Byte-half position of current code
  logic [16:0] range_end; // Last word touched, one bit wider to catch overflow
  logic        di_bad;    // Designator out of range
  logic [1:0]  dig;       // Wrapped digit position of current item

  // Next-state logic
  always_comb begin
    cnt       = desd_count(s_r.di);
    first_dg  = 2'(desd_nib(s_r.di, desd_pkg::DESD_NIB_FIRST));
    dig       = first_dg + s_r.idx[1:0];
    pos       = 3'(desd_nib(s_r.di, desd_pkg::DESD_NIB_HALF)) + s_r.idx;
    di_bad    = (desd_nib(s_r.di, desd_pkg::DESD_NIB_FIRST) > desd_pkg::DESD_MAX_DIGIT) ||
                (desd_nib(s_r.di, desd_pkg::DESD_NIB_COUNT) > desd_pkg::DESD_MAX_DIGIT);
    range_end = {1'b0, s_r.src} + 17'(cnt) - 17'd1;
    if (s_r.op == desd_pkg::DESD_OP_SEGMENT) begin
      // Segment checks the destination span instead of the source
      di_bad    = di_bad ||
                  (desd_nib(s_r.di, desd_pkg::DESD_NIB_HALF) > desd_pkg::DESD_MAX_HALF) ||
                  (desd_nib(s_r.di, desd_pkg::DESD_NIB_TOP) != desd_pkg::DESD_ZERO_NIB);
      range_end = {1'b0, s_r.dst} +
                  17'((3'(desd_nib(s_r.di, desd_pkg::DESD_NIB_HALF)) + cnt - 3'd1) >> 1);
    end

    s_nxt          = s_r;
    s_nxt.mem.rd   = 1'b0;
    s_nxt.mem.wr   = 1'b0;
    s_nxt.done     = 1'b0;

    unique case (s_r.st)
      desd_pkg::DESD_ST_IDLE: begin
        if (req_valid) begin
          // RL1 RL11: condition off, answer only
          if (!req.exec_cond) begin
            s_nxt.st   = desd_pkg::DESD_ST_DONE;
          end else begin
            s_nxt.st      = desd_pkg::DESD_ST_CHECK;
            s_nxt.op      = req.op;
            s_nxt.di      = req.digit_designator;
            s_nxt.src     = req.first_source_word;
            s_nxt.dst     = req.dest_word;
            s_nxt.last    = req.area_last;
            s_nxt.ind_bad = req.indirect_bad;
            s_nxt.err     = 1'b0;
          end
          s_nxt.busy  = 1'b1;
          s_nxt.idx   = 3'd0;
          s_nxt.phase = 1'b0;
        end
      end
      desd_pkg::DESD_ST_CHECK: begin
        // RL8 RL10 RL18: operand checks abort before any write
        if (s_r.ind_bad || di_bad || range_end > {1'b0, s_r.last}) begin
          s_nxt.err = 1'b1;
          s_nxt.st  = desd_pkg::DESD_ST_DONE;
        end else begin
          s_nxt.st  = desd_pkg::DESD_ST_RD;
        end
      end
      desd_pkg::DESD_ST_RD: begin
        // First read: result word for encode, source word for segment
        s_nxt.mem.rd = 1'b1;
        s_nxt.st     = desd_pkg::DESD_ST_WAIT;
        if (s_r.op == desd_pkg::DESD_OP_ENCODE) begin
          // RL4: consecutive source words
          s_nxt.mem.addr = s_r.phase ? s_r.src + 16'(s_r.idx) : s_r.dst;
        end else begin
          // RL13: word holding the current byte half
          s_nxt.mem.addr = s_r.phase ? s_r.dst + 16'(pos >> 1) : s_r.src;
        end
      end
      desd_pkg::DESD_ST_WAIT: begin
        if (mem_rsp.rd_valid) begin
          if (!s_r.phase) begin
            // Keep the first word, then loop
            if (s_r.op == desd_pkg::DESD_OP_ENCODE) begin
              s_nxt.buf_w = mem_rsp.rdata;
            end else begin
              s_nxt.src_w = mem_rsp.rdata;
            end
            s_nxt.phase = 1'b1;
            s_nxt.st    = desd_pkg::DESD_ST_RD;
          end else if (s_r.op == desd_pkg::DESD_OP_ENCODE) begin
            // RL9: zero source has no highest bit
            if (mem_rsp.rdata == desd_pkg::DESD_WORD_RST) begin
              s_nxt.err = 1'b1;
              s_nxt.st  = desd_pkg::DESD_ST_DONE;
            end else begin
              // RL2 RL5 RL6: digit index wraps in the result
              s_nxt.buf_w[dig*4 +: 4] = desd_msb(mem_rsp.rdata);
              if (s_r.idx == cnt - 3'd1) begin
                s_nxt.mem.wr    = 1'b1;
                s_nxt.mem.addr  = s_r.dst;
                s_nxt.mem.wdata = s_nxt.buf_w;
                s_nxt.st        = desd_pkg::DESD_ST_WR;
              end else begin
                s_nxt.idx = s_r.idx + 3'd1;
                s_nxt.st  = desd_pkg::DESD_ST_RD;
              end
            end
          end else begin
            // RL12 RL14 RL15 RL16 RL17: wrapped digit to code into one half
            s_nxt.mem.wdata = mem_rsp.rdata;
            s_nxt.mem.wdata[pos[0]*8 +: 8] = desd_seg(s_r.src_w[dig*4 +: 4]);
            s_nxt.mem.wr    = 1'b1;
            s_nxt.st        = desd_pkg::DESD_ST_WR;
          end
        end
      end
      desd_pkg::DESD_ST_WR: begin
        // Segment loops once per code; encode writes once
        if (s_r.op == desd_pkg::DESD_OP_SEGMENT && s_r.idx != cnt - 3'd1) begin
          s_nxt.idx = s_r.idx + 3'd1;
          s_nxt.st  = desd_pkg::DESD_ST_RD;
        end else begin
          s_nxt.st  = desd_pkg::DESD_ST_DONE;
        end
      end
      desd_pkg::DESD_ST_DONE: begin
        s_nxt.done = 1'b1;
        s_nxt.busy = 1'b0;
        s_nxt.st   = desd_pkg::DESD_ST_IDLE;
      end
      default: begin
        // Illegal code recovers to idle
        s_nxt.st   = desd_pkg::DESD_ST_IDLE;
        s_nxt.busy = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Single state register, constant reset values
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_r         <= '0;
      s_r.st      <= desd_pkg::DESD_ST_IDLE;
      s_r.op      <= desd_pkg::DESD_OP_ENCODE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, straight from flip-flops
  // ----------------------------------------------------------------
  assign busy       = s_r.busy;
  assign done       = s_r.done;
  assign error_flag = s_r.err;
  assign mem_req    = s_r.mem;

endmodule

// ==== desd_pkg.sv ====
package desd_pkg;

  // ----------------------------------------------------------------
  // Widths and field positions
  // ----------------------------------------------------------------
  localparam int unsigned DESD_WORD_W     = 16;   // Controller word
  localparam int unsigned DESD_ADDR_W     = 16;   // Default word address width
  localparam int unsigned DESD_NIB_FIRST  = 0;    // Designator digit: first digit
  localparam int unsigned DESD_NIB_COUNT  = 1;    // Designator digit: count minus one
  localparam int unsigned DESD_NIB_HALF   = 2;    // Designator digit: first byte half
  localparam int unsigned DESD_NIB_TOP    = 3;    // Designator digit: unused, must be zero for segment decode

  // Largest legal designator digit values
  localparam logic [3:0]  DESD_MAX_DIGIT  = 4'h3;
  localparam logic [3:0]  DESD_MAX_HALF   = 4'h1;
  localparam logic [3:0]  DESD_ZERO_NIB   = 4'h0;

  // Reset values
  localparam logic [15:0] DESD_WORD_RST   = 16'h0000;

  // ----------------------------------------------------------------
  // Operations and states
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    DESD_OP_ENCODE  = 1'b0,               // Highest set bit to hex digit
    DESD_OP_SEGMENT = 1'b1                // Hex digit to segment code
  } desd_op_type;

  typedef enum logic [5:0] {
    DESD_ST_IDLE  = 6'b00_0001,
    DESD_ST_CHECK = 6'b00_0010,
    DESD_ST_RD    = 6'b00_0100,
    DESD_ST_WAIT  = 6'b00_1000,
    DESD_ST_WR    = 6'b01_0000,
    DESD_ST_DONE  = 6'b10_0000
  } desd_state_type;

  // ----------------------------------------------------------------
  // Carriers between sequencer, memory and block
  // ----------------------------------------------------------------
  typedef struct packed {
    desd_op_type      op;                 // Which conversion
    logic             exec_cond;          // Execution condition
    logic [15:0]      digit_designator;   // Designator word
    logic [15:0]      first_source_word;  // Source word address
    logic [15:0]      dest_word;          // Result or first destination address
    logic [15:0]      area_last;          // Last address of the checked data area
    logic             indirect_bad;       // Indirect operand pointer invalid
  } desd_req_type;

  typedef struct packed {
    logic             rd;                 // Read strobe, one cycle
    logic             wr;                 // Write strobe, one cycle
    logic [15:0]      addr;               // Word address
    logic [15:0]      wdata;              // Write data
  } desd_mem_req_type;

  typedef struct packed {
    logic             rd_valid;           // Read data present, one cycle
    logic [15:0]      rdata;              // Read data
  } desd_mem_rsp_type;

endpackage

// ==== desd_mem.sv ====
`timescale 1ns/10ps
module desd_mem (
  // Clock and answer delay
  input  wire logic                       clk,
  input  wire logic [3:0]                 lat,
  // Block side
  input  wire desd_pkg::desd_mem_req_type mem_req,
  output desd_pkg::desd_mem_rsp_type      mem_rsp
);
  logic [15:0] mem [0:255];  // Operand words
  logic [15:0] q_r;          // Word held for the answer
  logic [3:0]  cnt_r = 4'h0; // Cycles left before answering
  initial mem_rsp = '0;
  // Answer a read after lat cycles; idle data toggles so stale data never passes
  always @(posedge clk) begin
    mem_rsp.rd_valid <= 1'b0;
    mem_rsp.rdata    <= ~mem_rsp.rdata;
    if (mem_req.wr) begin
      mem[mem_req.addr[7:0]] <= mem_req.wdata;
    end
    if (mem_req.rd) begin
      q_r   <= mem[mem_req.addr[7:0]];
      cnt_r <= lat;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
      if (cnt_r == 4'h1) begin
        mem_rsp.rd_valid <= 1'b1;
        mem_rsp.rdata    <= q_r;
      end
    end
  end
endmodule

// ==== desd_codec_chk.sv ====
`timescale 1ns/10ps
module desd_codec_chk (
  // Clock and reset
  input wire logic                       clk,
  input wire logic                       reset,
  // Sequencer side
  input wire logic                       req_valid,
  input wire desd_pkg::desd_req_type     req,
  input wire logic                       busy,
  input wire logic                       done,
  input wire logic                       error_flag,
  // Memory side
  input wire desd_pkg::desd_mem_req_type mem_req,
  input wire desd_pkg::desd_mem_rsp_type mem_rsp
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  desd_pkg::desd_req_type req_r; // Request now running
  logic                   acc;   // Request taken
  logic                   run;   // Executed request taken
  logic                   seg;   // Segment decode asked
  logic [15:0]            dd;    // Designator
  assign acc = req_valid && !busy;
  assign run = acc && req.exec_cond;
  assign seg = req.op == desd_pkg::DESD_OP_SEGMENT;
  assign dd  = req.digit_designator;
  // Hold the taken request for address checks
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      req_r <= '0;
    end else if (acc) begin
      req_r <= req;
    end
  end
  a_skip_quiet: assert property (acc && !req.exec_cond |=>
    busy && !mem_req.rd && $stable(error_flag) ##1 done && $stable(error_flag)) else $error("skip not quiet");
  a_desig_err: assert property (run && (dd[3:0] > 4'h3 || dd[7:4] > 4'h3)
    |=> !mem_req.rd [*2] ##1 done && error_flag) else $error("bad designator not flagged");
  a_half_err: assert property (run && seg && (dd[11:8] > 4'h1 || dd[15:12] != 4'h0)
    |=> !mem_req.rd [*2] ##1 done && error_flag) else $error("bad half digit not flagged");
  a_indirect_err: assert property (run && req.indirect_bad
    |=> !mem_req.rd [*2] ##1 done && error_flag) else $error("bad indirect not flagged");
  a_enc_range: assert property (run && !seg && 17'(req.first_source_word) + 17'(dd[7:4]) > 17'(req.area_last)
    |=> !mem_req.rd [*2] ##1 done && error_flag) else $error("source range not flagged");
  a_seg_range: assert property (run && seg && 17'(req.dest_word) + 17'((5'(dd[11:8]) + 5'(dd[7:4])) >> 1) >
    17'(req.area_last) |=> !mem_req.rd [*2] ##1 done && error_flag) else $error("dest range not flagged");
  a_write_clean: assert property (mem_req.wr |-> !error_flag) else $error("write during error");
  a_enc_dest: assert property (mem_req.wr && req_r.op == desd_pkg::DESD_OP_ENCODE
    |-> mem_req.addr == req_r.dest_word ##2 done) else $error("encode write misplaced");
  a_seg_area: assert property (mem_req.wr && req_r.op == desd_pkg::DESD_OP_SEGMENT
    |-> mem_req.addr - req_r.dest_word <= 16'h0002 && mem_req.addr <= req_r.area_last) else $error("segment write out");
endmodule
bind desd_codec desd_codec_chk chk_i (.clk(clk), .reset(reset), .req_valid(req_valid), .req(req), .busy(busy),
  .done(done), .error_flag(error_flag), .mem_req(mem_req), .mem_rsp(mem_rsp));

// ==== digit_encode_segment_decode_bench.sv ====
`timescale 1ns/10ps
module digit_encode_segment_decode_bench;
  localparam logic [7:0] SEG [16] = '{8'h3F, 8'h06, 8'h5B, 8'h4F, 8'h66, 8'h6D, 8'h7D, 8'h27,
                                     8'h7F, 8'h6F, 8'h77, 8'h7C, 8'h39, 8'h5E, 8'h79, 8'h71};
  logic                       clk = 1'b0;
  logic                       reset = 1'b1;
  logic                       req_valid = 1'b0;
  desd_pkg::desd_req_type     req = '0;
  logic                       busy, done, error_flag;
  desd_pkg::desd_mem_req_type mem_req;
  desd_pkg::desd_mem_rsp_type mem_rsp;
  logic [3:0]                 lat = 4'h1;  // Memory answer delay
  int                         err_total = 0;
  int                         checks_done = 0;
  logic [15:0]                exp [4];     // Expected destination words
  always #5 clk = ~clk;
  desd_codec uut (.clk(clk), .reset(reset), .req_valid(req_valid), .req(req), .busy(busy), .done(done),
                  .error_flag(error_flag), .mem_req(mem_req), .mem_rsp(mem_rsp));
  desd_mem mem_i (.clk(clk), .lat(lat), .mem_req(mem_req), .mem_rsp(mem_rsp));
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    checks_done++;
    if (got !== want) begin
      err_total++;
      $display("ERROR at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  // One request, result word at 0x40, then finish pulse and flag
  task automatic go(input logic op, input logic ex, input logic [15:0] dd, input logic [15:0] src,
                    input logic [15:0] last, input logic ind, input logic err);
    int n;
    n = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{desd_pkg::desd_op_type'(op), ex, dd, src, 16'h0040, last, ind};
    @(posedge clk);
    req_valid <= 1'b0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (done !== 1'b1 && n < 200);
    chk({15'h0000, done}, 16'h0001);
    chk({15'h0000, error_flag}, {15'h0000, err});
  endtask
  function automatic logic [3:0] top_bit(input logic [15:0] w);
    top_bit = 4'h0;
    for (int b = 0; b < 16; b++) begin
      if (w[b]) begin
        top_bit = 4'(b);
      end
    end
  endfunction
  // Encode words at 0x10 into the result word; untouched digits must survive
  task automatic t_encode(input logic [15:0] dd);
    logic [15:0] want;
    want = 16'hA5C3;
    mem_i.mem[64] = want;
    for (int i = 0; i <= dd[7:4]; i++) begin
      want[4*((dd[3:0] + i) % 4) +: 4] = top_bit(mem_i.mem[16 + i]);
    end
    go(1'b0, 1'b1, dd, 16'h0010, 16'h00FF, 1'b0, 1'b0);
    chk(mem_i.mem[64], want);
    $display("encode %h done", dd);
  endtask
  // Decode one source word into segment codes; other byte halves must survive
  task automatic t_segment(input logic [15:0] dd, input logic [15:0] src);
    logic [3:0] d;
    int         p;
    mem_i.mem[48] = src;
    for (int k = 0; k < 4; k++) begin
      exp[k] = 16'h8080 ^ 16'(k);
      mem_i.mem[64 + k] = exp[k];
    end
    for (int i = 0; i <= dd[7:4]; i++) begin
      d = src[4*((dd[3:0] + i) % 4) +: 4];
      p = dd[11:8] + i;
      exp[p / 2][8*(p % 2) +: 8] = SEG[d];
    end
    go(1'b1, 1'b1, dd, 16'h0030, 16'h00FF, 1'b0, 1'b0);
    for (int k = 0; k < 4; k++) begin
      chk(mem_i.mem[64 + k], exp[k]);
    end
    $display("segment %h done", dd);
  endtask
  // Faults: zero word, then skips keep the set flag, then refused operands
  task automatic t_errors();
    logic [15:0] keep;
    keep = mem_i.mem[64];
    mem_i.mem[17] = 16'h0000;
    go(1'b0, 1'b1, 16'h0010, 16'h0010, 16'h00FF, 1'b0, 1'b1);
    go(1'b0, 1'b0, 16'h0030, 16'h0010, 16'h00FF, 1'b0, 1'b1);
    go(1'b1, 1'b0, 16'h0030, 16'h0030, 16'h00FF, 1'b0, 1'b1);
    go(1'b0, 1'b1, 16'h0004, 16'h0010, 16'h00FF, 1'b0, 1'b1);
    go(1'b0, 1'b1, 16'h0040, 16'h0010, 16'h00FF, 1'b0, 1'b1);
    go(1'b0, 1'b1, 16'h0030, 16'h0010, 16'h0012, 1'b0, 1'b1);
    go(1'b1, 1'b1, 16'h0200, 16'h0030, 16'h00FF, 1'b0, 1'b1);
    go(1'b1, 1'b1, 16'h1000, 16'h0030, 16'h00FF, 1'b0, 1'b1);
    go(1'b1, 1'b1, 16'h0110, 16'h0030, 16'h0040, 1'b0, 1'b1);
    go(1'b0, 1'b1, 16'h0000, 16'h0010, 16'h00FF, 1'b1, 1'b1);
    go(1'b1, 1'b1, 16'h0000, 16'h0030, 16'h00FF, 1'b1, 1'b1);
    chk(mem_i.mem[64], keep);
    $display("errors done");
  endtask
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    mem_i.mem[16] = 16'h8001;
    mem_i.mem[17] = 16'h0003;
    mem_i.mem[18] = 16'h0400;
    mem_i.mem[19] = 16'h0100;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    t_encode(16'h0030);
    t_encode(16'h0012);
    lat <= 4'h3;
    t_encode(16'h0013);
    t_segment(16'h0030, 16'h3210);
    lat <= 4'h1;
    t_segment(16'h0130, 16'h7654);
    t_segment(16'h0030, 16'hBA98);
    t_segment(16'h0130, 16'hFEDC);
    t_segment(16'h0032, 16'h5A3C);
    t_errors();
    wrap_up();
  end
  // Hang guard, well past the expected run length
  initial begin
    #200_000;
    err_total++;
    $display("ERROR at %0t: run hung", $time);
    wrap_up();
  end
endmodule
